/* File: verilog/mdfsb_pkg.sv */
// What this block does
// - Bit 15 of every status word carries parity when parity is enabled, else zero.
// - Summary bit 8 shows a nonvolatile memory load fault.
// - Summary bit 7 shows a power-on reset was seen; it is 1 after reset.
// - Summary bit 6 shows a serial communication fault.
// - Summary bit 5 shows an output stage overcurrent.
// - Summary bit 2 shows undervoltage on charge pump, LDO output or LDO input.
// - Summary bit 1 shows an overtemperature warning or shutdown.
// - Summary bit 0 shows that any device fault is present.
// - Thermal bit 2 shows overtemperature shutdown near the analog LDO.
// - Thermal bit 1 shows an overtemperature warning.
// - Thermal bit 0 shows an overtemperature shutdown.
// - Supply bit 5 shows current-sense reference undervoltage.
// - Supply bit 4 shows charge pump undervoltage.
// - Supply bit 2 shows analog LDO output undervoltage.
// - Supply bit 0 shows analog LDO supply input undervoltage.
// - With parity enabled, read data MSB is replaced by the computed parity.
// - After the first header byte, the addressed device returns an 8-bit status.
`default_nettype none
package mdfsb_pkg;
  localparam int WORD_W = 16;
  localparam int BYTE_W = 8;
  localparam int ADDR_W = 8;
  localparam int ID_W = 4;
  localparam int OC_W = 6;

  // Word offsets
  localparam logic [7:0] ADDR_SUMMARY = 8'h00;
  localparam logic [7:0] ADDR_THERMAL = 8'h04;
  localparam logic [7:0] ADDR_SUPPLY = 8'h05;
  localparam logic [7:0] ADDR_OUTPUT = 8'h06;

  // Reset values
  localparam logic [15:0] SUMMARY_RST = 16'h0080;
  localparam logic [15:0] THERMAL_RST = 16'h0000;
  localparam logic [15:0] SUPPLY_RST = 16'h0000;
  localparam logic [15:0] OUTPUT_RST = 16'h0000;

  // Field positions
  localparam int PARITY_POS = 15;
  localparam int SUM_NVLOAD = 8;
  localparam int SUM_POR = 7;
  localparam int SUM_SERIAL = 6;
  localparam int SUM_OC = 5;
  localparam int SUM_SUPPLY = 2;
  localparam int SUM_THERMAL = 1;
  localparam int SUM_FAULT = 0;
  localparam int TH_LDO_SD = 2;
  localparam int TH_WARN = 1;
  localparam int TH_SD = 0;
  localparam int SUP_SENSE = 5;
  localparam int SUP_CHARGE_PUMP = 4;
  localparam int SUP_LDO_OUT = 2;
  localparam int SUP_LDO_IN = 0;
  localparam int OS_HS_LSB = 4;
  localparam int OS_LS_LSB = 0;

  // Header layout: rw, id, address, two reserved, parity
  localparam int HDR_RW = 15;
  localparam int HDR_ID_LSB = 11;
  localparam int HDR_ADDR_LSB = 3;
  localparam logic HDR_READ = 1'b1;
  localparam int BYTE_ID_LSB = 3;
  localparam logic [3:0] LAST_BIT = 4'hf;
  localparam logic [3:0] BYTE_LAST_BIT = 4'h7;

  typedef struct packed {
    logic nonvolatile_load_fault;
    logic serial_link_fault;
    logic [5:0] overcurrent_flag;
    logic ldo_thermal_shutdown_flag;
    logic thermal_warning_flag;
    logic thermal_shutdown_flag;
    logic sense_reference_low_flag;
    logic charge_pump_low_flag;
    logic ldo_output_low_flag;
    logic ldo_input_low_flag;
  } mdfsb_fault_t;
endpackage
`default_nettype wire

/* File: verilog/mdfsb_status_bank.sv */
`default_nettype none
module mdfsb_status_bank (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Detector levels and settings
  input wire mdfsb_pkg::mdfsb_fault_t fault_in,
  input wire logic parity_check_enable,
  input wire logic por_clear,
  input wire logic [3:0] device_id,
  // Serial port, sampled on sys_clk
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_sdi,
  output logic spi_sdo,
  output logic spi_sdo_oe_n
);
  logic [15:0] summary_r, thermal_r, supply_r, output_r;
  logic [15:0] summary_nxt, thermal_nxt, supply_nxt, output_nxt;
  logic por_r;
  logic sclk_q_r;
  logic [3:0] bit_cnt_r, bit_cnt_nxt;
  logic in_hdr_r, in_hdr_nxt;
  logic matched_r, matched_nxt;
  logic [15:0] shift_in_r, shift_in_nxt;
  logic [15:0] shift_out_r, shift_out_nxt;
  logic [7:0] rd_ptr_r, rd_ptr_nxt;
  logic sdo_nxt, oe_n_nxt;

  function automatic logic [15:0] with_parity(input logic [15:0] w, input logic en);
    logic [15:0] r;
    r = w;
    r[mdfsb_pkg::PARITY_POS] = en ? ^w[14:0] : 1'b0;
    return r;
  endfunction

  function automatic logic [15:0] word_at(input logic [7:0] a);
    logic [15:0] w;
    w = 16'h0000;
    case (a)
      mdfsb_pkg::ADDR_SUMMARY: w = summary_r;
      mdfsb_pkg::ADDR_THERMAL: w = thermal_r;
      mdfsb_pkg::ADDR_SUPPLY: w = supply_r;
      mdfsb_pkg::ADDR_OUTPUT: w = output_r;
      default: w = 16'h0000;
    endcase
    return with_parity(w, parity_check_enable);
  endfunction

  // Condensed fault terms
  wire supply_low = fault_in.charge_pump_low_flag | fault_in.ldo_output_low_flag
                    | fault_in.ldo_input_low_flag;
  wire thermal_any = fault_in.thermal_warning_flag | fault_in.thermal_shutdown_flag
                     | fault_in.ldo_thermal_shutdown_flag;
  wire oc_any = |fault_in.overcurrent_flag;
  wire fault_any = fault_in.nonvolatile_load_fault | fault_in.serial_link_fault | oc_any
                   | supply_low | thermal_any | fault_in.sense_reference_low_flag;

  always_comb begin
    summary_nxt = 16'h0000;
    summary_nxt[mdfsb_pkg::SUM_NVLOAD] = fault_in.nonvolatile_load_fault;
    summary_nxt[mdfsb_pkg::SUM_POR] = por_r;
    summary_nxt[mdfsb_pkg::SUM_SERIAL] = fault_in.serial_link_fault;
    summary_nxt[mdfsb_pkg::SUM_OC] = oc_any;
    summary_nxt[mdfsb_pkg::SUM_SUPPLY] = supply_low;
    summary_nxt[mdfsb_pkg::SUM_THERMAL] = thermal_any;
    summary_nxt[mdfsb_pkg::SUM_FAULT] = fault_any;
    thermal_nxt = 16'h0000;
    thermal_nxt[mdfsb_pkg::TH_LDO_SD] = fault_in.ldo_thermal_shutdown_flag;
    thermal_nxt[mdfsb_pkg::TH_WARN] = fault_in.thermal_warning_flag;
    thermal_nxt[mdfsb_pkg::TH_SD] = fault_in.thermal_shutdown_flag;
    supply_nxt = 16'h0000;
    supply_nxt[mdfsb_pkg::SUP_SENSE] = fault_in.sense_reference_low_flag;
    supply_nxt[mdfsb_pkg::SUP_CHARGE_PUMP] = fault_in.charge_pump_low_flag;
    supply_nxt[mdfsb_pkg::SUP_LDO_OUT] = fault_in.ldo_output_low_flag;
    supply_nxt[mdfsb_pkg::SUP_LDO_IN] = fault_in.ldo_input_low_flag;
    output_nxt = 16'h0000;
    output_nxt[mdfsb_pkg::OS_HS_LSB +: 3] = fault_in.overcurrent_flag[5:3];
    output_nxt[mdfsb_pkg::OS_LS_LSB +: 3] = fault_in.overcurrent_flag[2:0];
  end

  // Status words are only ever loaded from detectors; the serial port has no write path
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      summary_r <= mdfsb_pkg::SUMMARY_RST;
    end else begin
      summary_r <= summary_nxt;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      thermal_r <= mdfsb_pkg::THERMAL_RST;
    end else begin
      thermal_r <= thermal_nxt;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      supply_r <= mdfsb_pkg::SUPPLY_RST;
    end else begin
      supply_r <= supply_nxt;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      output_r <= mdfsb_pkg::OUTPUT_RST;
    end else begin
      output_r <= output_nxt;
    end
  end

  // Only reset sets the power-on flag; a clear request drops it until the next reset
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      por_r <= 1'b1;
    end else if (por_clear) begin
      por_r <= 1'b0;
    end
  end

  // Serial framing
  wire cs_act = ~spi_cs_n;
  wire sclk_fall = cs_act & sclk_q_r & ~spi_sclk;
  wire sclk_rise = cs_act & ~sclk_q_r & spi_sclk;
  wire [15:0] word_in = {shift_in_r[14:0], spi_sdi};
  wire [3:0] byte_id = word_in[mdfsb_pkg::BYTE_ID_LSB +: mdfsb_pkg::ID_W];
  wire hdr_read = word_in[mdfsb_pkg::HDR_RW] == mdfsb_pkg::HDR_READ;
  wire [7:0] hdr_addr = word_in[mdfsb_pkg::HDR_ADDR_LSB +: mdfsb_pkg::ADDR_W];
  wire [7:0] rd_ptr_inc = rd_ptr_r + 8'h01;
  wire [15:0] status_word = with_parity(summary_r, parity_check_enable);

  always_comb begin
    bit_cnt_nxt = bit_cnt_r;
    in_hdr_nxt = in_hdr_r;
    matched_nxt = matched_r;
    shift_in_nxt = shift_in_r;
    shift_out_nxt = shift_out_r;
    rd_ptr_nxt = rd_ptr_r;
    sdo_nxt = spi_sdo;
    oe_n_nxt = spi_sdo_oe_n;
    if (!cs_act) begin
      // Outside a frame the pin floats and framing restarts
      bit_cnt_nxt = 4'h0;
      in_hdr_nxt = 1'b1;
      matched_nxt = 1'b0;
      sdo_nxt = 1'b0;
      oe_n_nxt = 1'b1;
    end else if (sclk_fall) begin
      shift_in_nxt = word_in;
      bit_cnt_nxt = bit_cnt_r + 4'h1;
      if (in_hdr_r && bit_cnt_r == mdfsb_pkg::BYTE_LAST_BIT) begin
        matched_nxt = byte_id == device_id;
        shift_out_nxt = {status_word[7:0], 8'h00};
      end else if (bit_cnt_r == mdfsb_pkg::LAST_BIT) begin
        in_hdr_nxt = 1'b0;
        if (in_hdr_r) begin
          // A write header keeps the read pointer, so reads can continue elsewhere
          if (matched_r && hdr_read) begin
            rd_ptr_nxt = hdr_addr;
          end
          shift_out_nxt = word_at((matched_r && hdr_read) ? hdr_addr : rd_ptr_r);
        end else begin
          // Incoming data words are dropped: every word here is read-only
          rd_ptr_nxt = rd_ptr_inc;
          shift_out_nxt = word_at(rd_ptr_inc);
        end
      end
    end else if (sclk_rise && matched_r) begin
      sdo_nxt = shift_out_r[15];
      shift_out_nxt = {shift_out_r[14:0], 1'b0};
      oe_n_nxt = 1'b0;
    end
  end

  // Resets to the idle clock level so that no false edge follows reset
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sclk_q_r <= 1'b0;
    end else begin
      sclk_q_r <= spi_sclk;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      bit_cnt_r <= 4'h0;
    end else begin
      bit_cnt_r <= bit_cnt_nxt;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      in_hdr_r <= 1'b1;
    end else begin
      in_hdr_r <= in_hdr_nxt;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      matched_r <= 1'b0;
    end else begin
      matched_r <= matched_nxt;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      shift_in_r <= 16'h0000;
    end else begin
      shift_in_r <= shift_in_nxt;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      shift_out_r <= 16'h0000;
    end else begin
      shift_out_r <= shift_out_nxt;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_ptr_r <= 8'h00;
    end else begin
      rd_ptr_r <= rd_ptr_nxt;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      spi_sdo <= 1'b0;
    end else begin
      spi_sdo <= sdo_nxt;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      spi_sdo_oe_n <= 1'b1;
    end else begin
      spi_sdo_oe_n <= oe_n_nxt;
    end
  end
endmodule
`default_nettype wire

/* File: verification/mdfsb_status_monitor.sv */
`default_nettype none
module mdfsb_status_monitor (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Observed pins
  input wire logic por_clear,
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_sdo,
  input wire logic spi_sdo_oe_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic sclk_q_r;
  logic por_seen_r;
  logic [7:0] rise_cnt_r;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sclk_q_r <= 1'b0;
      por_seen_r <= 1'b1;
      rise_cnt_r <= 8'h00;
    end else begin
      sclk_q_r <= spi_sclk;
      if (por_clear) por_seen_r <= 1'b0;
      if (spi_cs_n) rise_cnt_r <= 8'h00;
      else if (spi_sclk && !sclk_q_r) rise_cnt_r <= rise_cnt_r + 8'h01;
    end
  end
  a_idle_released: assert property (spi_cs_n [*3] |-> spi_sdo_oe_n && !spi_sdo)
    else $error("pin driven outside a frame");
  a_sdo_held_low: assert property (!spi_sdo_oe_n && !spi_sclk && !$past(spi_sclk)
    && !$past(spi_sclk, 2) |-> $stable(spi_sdo)) else $error("data moved without a rise");
  a_oe_in_frame: assert property (!spi_sdo_oe_n |-> !$past(spi_cs_n, 2))
    else $error("driving after frame end");
  a_oe_at_ninth: assert property ($fell(spi_sdo_oe_n) |-> rise_cnt_r == 8'h09)
    else $error("drive did not start at ninth rise");
  a_header_quiet: assert property (!spi_cs_n && rise_cnt_r < 8'h09 |-> spi_sdo_oe_n)
    else $error("driving during first header byte");
  a_oe_holds_frame: assert property (!spi_sdo_oe_n && !spi_cs_n |=> !spi_sdo_oe_n)
    else $error("drive dropped inside a frame");
  a_reset_release: assert property ($past(sys_rst) |-> spi_sdo_oe_n && !spi_sdo)
    else $error("pin not released after reset");
  a_status_por_bit: assert property ($fell(spi_sdo_oe_n) |-> spi_sdo == por_seen_r)
    else $error("status byte reset flag wrong");
  cover property ($fell(spi_sdo_oe_n));
  cover property (rise_cnt_r == 8'h80);
  cover property (por_clear && por_seen_r);
endmodule
bind mdfsb_status_bank mdfsb_status_monitor i_mon (.sys_clk(sys_clk), .sys_rst(sys_rst),
  .por_clear(por_clear), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_sdo(spi_sdo),
  .spi_sdo_oe_n(spi_sdo_oe_n));
`default_nettype wire

/* File: verification/mdfsb_spi_primary.sv */
`default_nettype none
module mdfsb_spi_primary (
  // Clock
  input wire logic sys_clk,
  // Serial pins
  output logic spi_sclk,
  output logic spi_cs_n,
  output logic spi_sdi,
  input wire logic spi_sdo,
  input wire logic spi_sdo_oe_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] rx_q [8];
  logic oe_seen;
  initial begin
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    spi_sdi = 1'b0;
  end
  // Four system clocks a phase; a released pin reads as the inverse of its last level
  task automatic frame(input logic [15:0] hdr, input int n_words);
    logic [15:0] tx;
    logic last;
    last = 1'b0;
    oe_seen = 1'b0;
    @(posedge sys_clk) spi_cs_n <= 1'b0;
    for (int w = 0; w <= n_words; w++) begin
      tx = (w == 0) ? hdr : 16'hffff;
      for (int b = 15; b >= 0; b--) begin
        repeat (4) @(posedge sys_clk);
        spi_sclk <= 1'b1;
        spi_sdi <= tx[b];
        repeat (4) @(posedge sys_clk);
        last = spi_sdo_oe_n ? ~last : spi_sdo;
        oe_seen = oe_seen | ~spi_sdo_oe_n;
        rx_q[w][b] = last;
        spi_sclk <= 1'b0;
      end
    end
    repeat (4) @(posedge sys_clk);
    spi_cs_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
  endtask
endmodule
`default_nettype wire

/* File: verification/mdfsb_status_bank_tb.sv */
`default_nettype none
module mdfsb_status_bank_tb;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic par_en;
    logic [14:0] flt;
    logic [15:0] sum, th, sup, os;
  } mdfsb_row_t;
  logic sys_clk, sys_rst, parity_check_enable, por_clear;
  mdfsb_pkg::mdfsb_fault_t fault_in;
  logic [3:0] device_id;
  logic spi_sclk, spi_cs_n, spi_sdi, spi_sdo, spi_sdo_oe_n;
  int n_errors = 0;
  int samples_checked = 0;
  mdfsb_row_t rows [8] = '{
    {1'b0, 15'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000},
    {1'b1, 15'h4000, 16'h0101, 16'h0000, 16'h0000, 16'h0000},
    {1'b0, 15'h2000, 16'h0041, 16'h0000, 16'h0000, 16'h0000},
    {1'b1, 15'h1080, 16'h0021, 16'h0000, 16'h0000, 16'h0041},
    {1'b1, 15'h0020, 16'h0003, 16'h8002, 16'h0000, 16'h0000},
    {1'b0, 15'h0050, 16'h0003, 16'h0005, 16'h0000, 16'h0000},
    {1'b1, 15'h0008, 16'h8001, 16'h0000, 16'h8020, 16'h0000},
    {1'b1, 15'h0007, 16'h0005, 16'h0000, 16'h8015, 16'h0000}};
  mdfsb_status_bank i_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .fault_in(fault_in),
    .parity_check_enable(parity_check_enable), .por_clear(por_clear), .device_id(device_id),
    .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_sdi(spi_sdi), .spi_sdo(spi_sdo),
    .spi_sdo_oe_n(spi_sdo_oe_n));
  mdfsb_spi_primary i_host (.sys_clk(sys_clk), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
    .spi_sdi(spi_sdi), .spi_sdo(spi_sdo), .spi_sdo_oe_n(spi_sdo_oe_n));
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  function automatic logic [15:0] hdr(input logic rd, input logic [3:0] id, input logic [7:0] a);
    return {rd, id, a, 3'b000};
  endfunction
  task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %0t word %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic reset_and_clear(input logic [15:0] exp_por, input logic [15:0] exp_clr);
    @(posedge sys_clk) sys_rst <= 1'b1;
    repeat (10) @(posedge sys_clk);
    sys_rst <= 1'b0;
    i_host.frame(hdr(1'b1, 4'h5, 8'h00), 1);
    check_word(i_host.rx_q[1], exp_por);
    @(posedge sys_clk) por_clear <= 1'b1;
    @(posedge sys_clk) por_clear <= 1'b0;
    i_host.frame(hdr(1'b1, 4'h5, 8'h00), 1);
    check_word(i_host.rx_q[1], exp_clr);
  endtask
  initial begin
    sys_rst = 1'b1;
    parity_check_enable = 1'b0;
    por_clear = 1'b0;
    fault_in = '0;
    device_id = 4'h5;
    reset_and_clear(16'h0080, 16'h0000);
    $display("Reset test done");
    foreach (rows[i]) begin
      @(posedge sys_clk);
      parity_check_enable <= rows[i].par_en;
      fault_in <= mdfsb_pkg::mdfsb_fault_t'(rows[i].flt);
      i_host.frame(hdr(1'b1, 4'h5, 8'h00), 7);
      check_word({8'h00, i_host.rx_q[0][7:0]}, {8'h00, rows[i].sum[7:0]});
      check_word(i_host.rx_q[1], rows[i].sum);
      for (int a = 2; a <= 4; a++) check_word(i_host.rx_q[a], 16'h0000);
      check_word(i_host.rx_q[5], rows[i].th);
      check_word(i_host.rx_q[6], rows[i].sup);
      check_word(i_host.rx_q[7], rows[i].os);
      $display("Row %0d done", i);
    end
    // Another device's id must leave the pin released all frame
    i_host.frame(hdr(1'b1, 4'ha, 8'h04), 1);
    check_word({15'h0000, i_host.oe_seen}, 16'h0000);
    i_host.frame(hdr(1'b0, 4'h5, 8'h04), 2);
    i_host.frame(hdr(1'b1, 4'h5, 8'h04), 1);
    check_word(i_host.rx_q[1], rows[7].th);
    $display("Refusal tests done");
    reset_and_clear(16'h8085, 16'h0005);
    $display("Mid-run reset test done");
    end_of_test();
  end
  initial begin
    repeat (40000) @(posedge sys_clk);
    n_errors++;
    $display("CHECK FAILED %0t watchdog expired", $time);
    end_of_test();
  end
endmodule
`default_nettype wire
